// *** shared/ahp_pkg.sv ***
// Constants, field layouts and state codes for the converter host port block.
// Assumes a single core clock; all users import the whole package.
package ahp_pkg;

    // ------------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------------
    localparam int DATA_W = 12;
    localparam int CR_W = DATA_W - 2;
    localparam int CHAN_N = 4;
    localparam int CHAN_W = 2;
    localparam int PIPE_LATENCY = 7;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam int TRIG_W = 4;
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int INT_OSC_PERIOD_NS = 50;
    localparam int OSC_DIV_CYCLES = (INT_OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Control register selection on the two top data lines
    // ------------------------------------------------------------------
    localparam logic [1:0] CR_ADDR_0 = 2'h0;
    localparam logic [1:0] CR_ADDR_1 = 2'h1;

    // ------------------------------------------------------------------
    // Control register 0 fields
    // ------------------------------------------------------------------
    localparam int CR0_EXT_REF_BIT = 0;
    localparam int CR0_SINGLE_BIT = 1;
    localparam int CR0_CHAN_LSB = 2;
    localparam int CR0_DIFF_LSB = 6;
    localparam logic [CR_W-1:0] CR0_RESET = 10'h000;

    // ------------------------------------------------------------------
    // Control register 1 fields
    // ------------------------------------------------------------------
    localparam int CR1_STROBE_WO_BIT = 0;
    localparam int CR1_FLAG_HIGH_BIT = 1;
    localparam int CR1_FLAG_PULSE_BIT = 2;
    localparam int CR1_FIFO_RESET_BIT = 3;
    localparam int CR1_TRIG_LSB = 4;
    localparam logic [CR_W-1:0] CR1_RESET = 10'h010;

    // ------------------------------------------------------------------
    // Software register port map
    // ------------------------------------------------------------------
    localparam logic [REG_ADDR_W-1:0] OFS_IRQ_STATUS = 8'h00;
    localparam logic [REG_ADDR_W-1:0] OFS_IRQ_MASK = 8'h04;
    localparam logic [REG_ADDR_W-1:0] OFS_CTRL0 = 8'h08;
    localparam logic [REG_ADDR_W-1:0] OFS_CTRL1 = 8'h0C;
    localparam logic [REG_ADDR_W-1:0] OFS_FIFO_STAT = 8'h10;

    localparam int IRQ_W = 4;
    localparam int IRQ_READY = 0;
    localparam int IRQ_OVERFLOW = 1;
    localparam int IRQ_UNDERFLOW = 2;
    localparam int IRQ_SINGLE_DONE = 3;

    // ------------------------------------------------------------------
    // Single conversion sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SC_IDLE = 3'b001,
        SC_CONV = 3'b010,
        SC_FLUSH = 3'b100
    } ahp_sc_e;

endpackage : ahp_pkg

// *** rtl/ahp_pipe.sv ***
// Conversion pipeline timing model: one slot per stage, advanced by a step.
// Assumes step_in comes from the host port top; inputs synchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none
module ahp_pipe
    import ahp_pkg::*;
#(
    parameter int STAGES = PIPE_LATENCY,
    parameter int WIDTH = DATA_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic clear_in,
    input wire logic step_in,
    input wire logic valid_in,
    input wire logic [WIDTH-1:0] data_in,
    output logic stb_out,
    output logic [WIDTH-1:0] data_out
);

    generate
        if (STAGES < 2 || WIDTH < 1) begin : g_bad_param
            $error("ahp_pipe: STAGES must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [STAGES-1:0] vld;
        logic [STAGES-1:0][WIDTH-1:0] dat;
        logic stb;
        logic [WIDTH-1:0] out;
    } ahp_pipe_s;

    ahp_pipe_s s_q;
    ahp_pipe_s s_d;

    // ------------------------------------------------------------------
    // Stage shift
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.stb = 1'b0;
        if (clear_in) begin
            s_d.vld = '0;
        end else if (step_in) begin
            // Sample leaves on the step after it reaches the last slot
            s_d.stb = s_q.vld[STAGES-1];
            s_d.out = s_q.dat[STAGES-1];
            for (int i = STAGES - 1; i > 0; i--) begin
                s_d.vld[i] = s_q.vld[i-1];
                s_d.dat[i] = s_q.dat[i-1];
            end
            s_d.vld[0] = valid_in;
            s_d.dat[0] = data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign stb_out = s_q.stb;
    assign data_out = s_q.out;

endmodule : ahp_pipe
`default_nettype wire

// *** rtl/ahp_top.sv ***
// Host port, conversion control and sample FIFO of a four-input converter.
// Assumes host pins synchronous to CORE_CLK_IN; the analog core supplies codes.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ahp_top
    import ahp_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter int OSC_DIV = OSC_DIV_CYCLES
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic CE_IN,
    input wire logic CHIP_SELECT_LOW_N_IN,
    input wire logic CHIP_SELECT_HIGH_IN,
    input wire logic WRITE_PIN_IN,
    input wire logic READ_SELECT_N_IN,
    input wire logic [DATA_W-1:0] DATA_IN,
    output logic [DATA_W-1:0] DATA_OUT,
    output logic DATA_OE_N_OUT,
    input wire logic CONV_PIN_IN,
    output logic SAMPLE_READY_FLAG_OUT,
    input wire logic [DATA_W-1:0] ANALOG_CODE_IN,
    output logic [CHAN_W-1:0] CHANNEL_INDEX_OUT,
    output logic [CHAN_N-1:0] CHANNEL_ENABLE_OUT,
    output logic [CHAN_N/2-1:0] DIFF_PAIR_OUT,
    output logic EXT_REF_SELECT_OUT,
    output logic SINGLE_MODE_OUT,
    output logic SAMPLE_HOLD_OUT,
    output logic CONVERT_STEP_OUT,
    input wire logic [REG_ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [REG_DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [REG_DATA_W-1:0] REG_RDATA_OUT,
    output logic IRQ_OUT
);

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int FILL_W = $clog2(FIFO_DEPTH + 1);
    localparam int OSC_W = $clog2(OSC_DIV + 1);

    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || OSC_DIV < 1) begin : g_bad_param
            $error("ahp_top: FIFO_DEPTH must be a power of two and OSC_DIV at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [CR_W-1:0] cr0;
        logic [CR_W-1:0] cr1;
        logic cfg_valid;
        logic wr_act;
        logic rd_act;
        logic [DATA_W-1:0] wr_data;
        logic pin_prev;
        logic [CHAN_W-1:0] chan;
        ahp_sc_e sc_state;
        logic [2:0] left;
        logic [OSC_W-1:0] osc;
        logic hold;
        logic pend;
        logic [DATA_W-1:0] pend_data;
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [FILL_W-1:0] fill;
        logic [DATA_W-1:0] dout;
        logic ready_prev;
        logic flag_pin;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [REG_DATA_W-1:0] rdata;
    } ahp_top_s;

    ahp_top_s s_q;
    ahp_top_s s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic sel;
    logic wr_now;
    logic rd_now;
    logic wr_end;
    logic rd_end;
    logic pin_fall;
    logic pin_rise;
    logic single_mode;
    logic [CHAN_N-1:0] chan_en;
    logic osc_tick;
    logic step;
    logic vin;
    logic pipe_clr;
    logic pipe_stb;
    logic [DATA_W-1:0] pipe_data;
    logic push;
    logic [DATA_W-1:0] push_data;
    logic push_ok;
    logic pop_ok;
    logic ready_cond;
    logic active;
    logic [FILL_W-1:0] trig_eff;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------
    // Next enabled channel after the current one
    // ------------------------------------------------------------------
    function automatic logic [CHAN_W-1:0] next_chan(input logic [CHAN_W-1:0] cur, input logic [CHAN_N-1:0] en);
        logic [CHAN_W-1:0] res;
        logic [CHAN_W-1:0] c;
        logic found;
        res = cur;
        found = 1'b0;
        for (int i = 1; i <= CHAN_N; i++) begin
            c = cur + CHAN_W'(i);
            if (!found && en[c]) begin
                res = c;
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_chan

    // ------------------------------------------------------------------
    // Host strobe decode
    // ------------------------------------------------------------------
    assign sel = CHIP_SELECT_HIGH_IN & ~CHIP_SELECT_LOW_N_IN;
    assign wr_now = sel & ~WRITE_PIN_IN;
    assign rd_now = sel & s_q.cfg_valid & ~wr_now & (s_q.cr1[CR1_STROBE_WO_BIT] ? ~READ_SELECT_N_IN
                                                                                : WRITE_PIN_IN);
    assign wr_end = s_q.wr_act & ~wr_now;
    assign rd_end = s_q.rd_act & ~rd_now;
    assign pin_fall = s_q.pin_prev & ~CONV_PIN_IN;
    assign pin_rise = ~s_q.pin_prev & CONV_PIN_IN;
    assign single_mode = s_q.cr0[CR0_SINGLE_BIT];
    assign chan_en = s_q.cr0[CR0_CHAN_LSB +: CHAN_N];
    assign osc_tick = (s_q.osc == OSC_W'(OSC_DIV - 1));
    assign trig_eff = (s_q.cr1[CR1_TRIG_LSB +: TRIG_W] == '0) ? FILL_W'(1)
                                                              : FILL_W'(s_q.cr1[CR1_TRIG_LSB +: TRIG_W]);

    ahp_pipe #(
        .STAGES(PIPE_LATENCY),
        .WIDTH(DATA_W)
    ) u_pipe (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .clear_in(pipe_clr),
        .step_in(step),
        .valid_in(vin),
        .data_in(ANALOG_CODE_IN),
        .stb_out(pipe_stb),
        .data_out(pipe_data)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        irq_set = '0;
        step = 1'b0;
        vin = 1'b0;
        pipe_clr = 1'b0;
        push = 1'b0;
        push_data = pipe_data;
        push_ok = 1'b0;
        pop_ok = 1'b0;
        s_d.wr_act = wr_now;
        s_d.rd_act = rd_now;
        s_d.pin_prev = CONV_PIN_IN;
        if (wr_now) begin
            s_d.wr_data = DATA_IN;
        end
        if (wr_end) begin
            s_d.cfg_valid = 1'b1;
            case (s_q.wr_data[DATA_W-1 -: 2])
                CR_ADDR_0: begin
                    s_d.cr0 = s_q.wr_data[CR_W-1:0];
                end
                CR_ADDR_1: begin
                    s_d.cr1 = s_q.wr_data[CR_W-1:0];
                    s_d.cr1[CR1_FIFO_RESET_BIT] = 1'b0;
                    pipe_clr = s_q.wr_data[CR1_FIFO_RESET_BIT];
                end
                default: begin
                end
            endcase
        end
        if (!single_mode) begin
            s_d.sc_state = SC_IDLE;
            s_d.hold = 1'b0;
            s_d.osc = '0;
            if (pin_fall && chan_en != '0) begin
                step = 1'b1;
                vin = 1'b1;
                s_d.hold = 1'b1;
                s_d.chan = next_chan(s_q.chan, chan_en);
            end
            if (pipe_stb) begin
                s_d.pend = 1'b1;
                s_d.pend_data = pipe_data;
            end
            if (pin_rise && s_q.pend) begin
                push = 1'b1;
                push_data = s_q.pend_data;
                s_d.pend = pipe_stb;
            end
        end else begin
            s_d.pend = 1'b0;
            push = pipe_stb;
            if (s_q.sc_state != SC_IDLE) begin
                s_d.osc = osc_tick ? '0 : s_q.osc + OSC_W'(1);
            end
            unique case (s_q.sc_state)
                SC_IDLE: begin
                    if (pin_fall && chan_en != '0) begin
                        s_d.hold = 1'b1;
                        s_d.chan = next_chan(CHAN_W'(CHAN_N - 1), chan_en);
                        s_d.left = 3'($countones(chan_en) - 1);
                        s_d.osc = '0;
                        s_d.sc_state = SC_CONV;
                    end
                end
                SC_CONV: begin
                    if (osc_tick) begin
                        step = 1'b1;
                        vin = 1'b1;
                        if (s_q.left == '0) begin
                            s_d.hold = 1'b0;
                            s_d.left = 3'(PIPE_LATENCY - 1);
                            s_d.sc_state = SC_FLUSH;
                        end else begin
                            s_d.left = s_q.left - 3'h1;
                            s_d.chan = next_chan(s_q.chan, chan_en);
                        end
                    end
                end
                SC_FLUSH: begin
                    if (osc_tick) begin
                        step = 1'b1;
                        if (s_q.left == '0) begin
                            s_d.sc_state = SC_IDLE;
                            irq_set[IRQ_SINGLE_DONE] = 1'b1;
                        end else begin
                            s_d.left = s_q.left - 3'h1;
                        end
                    end
                end
            endcase
        end
        // Sample FIFO
        if (push) begin
            if (s_q.fill == FILL_W'(FIFO_DEPTH)) begin
                irq_set[IRQ_OVERFLOW] = 1'b1;
            end else begin
                push_ok = 1'b1;
                s_d.mem[s_q.wr_ptr] = push_data;
                s_d.wr_ptr = s_q.wr_ptr + PTR_W'(1);
            end
        end
        if (rd_end) begin
            if (s_q.fill != '0) begin
                pop_ok = 1'b1;
                s_d.rd_ptr = s_q.rd_ptr + PTR_W'(1);
            end else begin
                irq_set[IRQ_UNDERFLOW] = 1'b1;
            end
        end
        s_d.fill = s_q.fill + FILL_W'(push_ok) - FILL_W'(pop_ok);
        if (!rd_now) begin
            s_d.dout = s_q.mem[s_q.rd_ptr];
        end
        if (pipe_clr) begin
            s_d.wr_ptr = '0;
            s_d.rd_ptr = '0;
            s_d.fill = '0;
            s_d.pend = 1'b0;
        end
        // Ready flag
        ready_cond = (s_q.fill >= trig_eff);
        s_d.ready_prev = ready_cond;
        active = s_q.cr1[CR1_FLAG_PULSE_BIT] ? (ready_cond & ~s_q.ready_prev) : ready_cond;
        s_d.flag_pin = s_q.cr1[CR1_FLAG_HIGH_BIT] ? active : ~active;
        irq_set[IRQ_READY] = ready_cond & ~s_q.ready_prev;
        // Software register port
        irq_clr = '0;
        if (REG_WR_IN && REG_ADDR_IN == OFS_IRQ_STATUS) begin
            irq_clr = REG_WDATA_IN[IRQ_W-1:0];
        end
        if (REG_WR_IN && REG_ADDR_IN == OFS_IRQ_MASK) begin
            s_d.irq_mask = REG_WDATA_IN[IRQ_W-1:0];
        end
        s_d.irq_status = (s_q.irq_status & ~irq_clr) | irq_set;
        s_d.rdata = '0;
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                OFS_IRQ_STATUS: s_d.rdata = REG_DATA_W'(s_q.irq_status);
                OFS_IRQ_MASK: s_d.rdata = REG_DATA_W'(s_q.irq_mask);
                OFS_CTRL0: s_d.rdata = REG_DATA_W'(s_q.cr0);
                OFS_CTRL1: s_d.rdata = REG_DATA_W'(s_q.cr1);
                OFS_FIFO_STAT: s_d.rdata = REG_DATA_W'({s_q.cfg_valid, s_q.sc_state != SC_IDLE, s_q.fill});
                default: s_d.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.cr0 <= CR0_RESET;
            s_q.cr1 <= CR1_RESET;
            s_q.sc_state <= SC_IDLE;
            s_q.pin_prev <= 1'b1;
            s_q.flag_pin <= 1'b1;
        end else if (CE_IN) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign DATA_OUT = s_q.dout;
    assign DATA_OE_N_OUT = ~rd_now;
    assign SAMPLE_READY_FLAG_OUT = s_q.flag_pin;
    assign CHANNEL_INDEX_OUT = s_q.chan;
    assign CHANNEL_ENABLE_OUT = chan_en;
    assign DIFF_PAIR_OUT = s_q.cr0[CR0_DIFF_LSB +: CHAN_N/2];
    assign EXT_REF_SELECT_OUT = s_q.cr0[CR0_EXT_REF_BIT];
    assign SINGLE_MODE_OUT = single_mode;
    assign SAMPLE_HOLD_OUT = s_q.hold;
    assign CONVERT_STEP_OUT = step;
    assign REG_RDATA_OUT = s_q.rdata;
    assign IRQ_OUT = |(s_q.irq_status & s_q.irq_mask);

endmodule : ahp_top
`default_nettype wire

// *** tb/ahp_top_monitor.sv ***
// Checker for host pin, register port and conversion timing of ahp_top.
// Assumes it is bound to ahp_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ahp_top_monitor
    import ahp_pkg::*;
#(
    parameter int OSC_DIV = OSC_DIV_CYCLES
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic CHIP_SELECT_LOW_N_IN,
    input wire logic CHIP_SELECT_HIGH_IN,
    input wire logic WRITE_PIN_IN,
    input wire logic CONV_PIN_IN,
    input wire logic REG_RD_IN,
    input wire logic [DATA_W-1:0] DATA_OUT,
    input wire logic DATA_OE_N_OUT,
    input wire logic [REG_DATA_W-1:0] REG_RDATA_OUT,
    input wire logic EXT_REF_SELECT_OUT,
    input wire logic SINGLE_MODE_OUT,
    input wire logic SAMPLE_HOLD_OUT,
    input wire logic CONVERT_STEP_OUT
);
    logic host_wr;
    logic [7:0] gap_q;
    assign host_wr = CHIP_SELECT_HIGH_IN & ~CHIP_SELECT_LOW_N_IN & ~WRITE_PIN_IN;
    // ----------------------------------------
    // Cycles since the last pipeline step
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            gap_q <= 8'hFF;
        end else if (CONVERT_STEP_OUT) begin
            gap_q <= 8'h00;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    // ----------------------------------------
    // Assertions and cover points
    // ----------------------------------------
    a_oe_selected: assert property (!DATA_OE_N_OUT |-> CHIP_SELECT_HIGH_IN && !CHIP_SELECT_LOW_N_IN)
        else $error("bus driven without select");
    a_oe_no_write: assert property (!DATA_OE_N_OUT |-> WRITE_PIN_IN)
        else $error("bus driven during write");
    a_dout_steady: assert property (!DATA_OE_N_OUT && !$past(DATA_OE_N_OUT) |-> $stable(DATA_OUT))
        else $error("read word moved during read");
    a_rdata_idle: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == '0)
        else $error("read data outside answer cycle");
    a_cfg_after_write: assert property ($changed(EXT_REF_SELECT_OUT) || $changed(SINGLE_MODE_OUT)
        |-> $past(host_wr, 2) || $past(host_wr, 3))
        else $error("configuration changed without host write");
    a_hold_after_fall: assert property ($rose(SAMPLE_HOLD_OUT)
        |-> !$past(CONV_PIN_IN) || !$past(CONV_PIN_IN, 2) || !$past(CONV_PIN_IN, 3))
        else $error("hold without conversion pin fall");
    a_hold_pulse: assert property (!SINGLE_MODE_OUT && !$past(SINGLE_MODE_OUT) && SAMPLE_HOLD_OUT
        |=> !SAMPLE_HOLD_OUT)
        else $error("continuous hold longer than one cycle");
    a_step_spacing: assert property (SINGLE_MODE_OUT && CONVERT_STEP_OUT |-> gap_q >= OSC_DIV - 1)
        else $error("single mode step faster than oscillator");
    c_bus_read: cover property (!DATA_OE_N_OUT);
    c_single_step: cover property (SINGLE_MODE_OUT && CONVERT_STEP_OUT);
    c_hold: cover property ($rose(SAMPLE_HOLD_OUT));
endmodule : ahp_top_monitor
bind ahp_top ahp_top_monitor #(.OSC_DIV(OSC_DIV)) ahp_top_monitor_inst (
    .CORE_CLK_IN(CORE_CLK_IN),
    .RST_B_IN(RST_B_IN),
    .CHIP_SELECT_LOW_N_IN(CHIP_SELECT_LOW_N_IN),
    .CHIP_SELECT_HIGH_IN(CHIP_SELECT_HIGH_IN),
    .WRITE_PIN_IN(WRITE_PIN_IN),
    .CONV_PIN_IN(CONV_PIN_IN),
    .REG_RD_IN(REG_RD_IN),
    .DATA_OUT(DATA_OUT),
    .DATA_OE_N_OUT(DATA_OE_N_OUT),
    .REG_RDATA_OUT(REG_RDATA_OUT),
    .EXT_REF_SELECT_OUT(EXT_REF_SELECT_OUT),
    .SINGLE_MODE_OUT(SINGLE_MODE_OUT),
    .SAMPLE_HOLD_OUT(SAMPLE_HOLD_OUT),
    .CONVERT_STEP_OUT(CONVERT_STEP_OUT)
);
`default_nettype wire

// *** tb/ahp_host_model.sv ***
// Host processor model driving the parallel pins of the converter.
// Assumes the bench calls its tasks; released lines show the inverse value.
`timescale 1ns/100ps
`default_nettype none
module ahp_host_model
    import ahp_pkg::*;
(
    input wire logic clk_in,
    input wire logic [DATA_W-1:0] dev_data_in,
    input wire logic dev_oe_n_in,
    output logic cs_low_n_out = 1'b1,
    output logic cs_high_out = 1'b0,
    output logic write_pin_out = 1'b1,
    output logic read_n_out = 1'b1,
    output logic [DATA_W-1:0] bus_out
);
    logic [DATA_W-1:0] host_q = 12'h5A5;
    assign bus_out = !dev_oe_n_in ? dev_data_in : host_q;
    task automatic host_write(input logic [1:0] ra, input logic [CR_W-1:0] val);
        @(posedge clk_in);
        cs_high_out <= 1'b1;
        cs_low_n_out <= 1'b0;
        write_pin_out <= 1'b0;
        host_q <= {ra, val};
        @(posedge clk_in);
        cs_high_out <= 1'b0;
        cs_low_n_out <= 1'b1;
        write_pin_out <= 1'b1;
        host_q <= ~{ra, val};
        repeat (3) @(negedge clk_in);
    endtask : host_write
    task automatic host_read(input logic csh, input logic csl_n, input logic rdn,
                             output logic [DATA_W-1:0] d, output logic drv);
        @(posedge clk_in);
        cs_high_out <= csh;
        cs_low_n_out <= csl_n;
        read_n_out <= rdn;
        repeat (2) @(posedge clk_in);
        drv = !dev_oe_n_in;
        d = bus_out;
        cs_high_out <= 1'b0;
        cs_low_n_out <= 1'b1;
        read_n_out <= 1'b1;
        @(posedge clk_in);
    endtask : host_read
endmodule : ahp_host_model
`default_nettype wire

// *** tb/ahp_top_tb_top.sv ***
// Bench for ahp_top: host pin traffic, register port and both conversion modes.
// Assumes the checker is bound and the host model stands on the pins.
`timescale 1ns/100ps
`default_nettype none
module ahp_top_tb_top
    import ahp_pkg::*;
;
    logic clk, rst_b, conv, rd, wr, csl_n, csh, wp, rdn, oe_n, flag, irq, drv, ext_ref, single, hold, step;
    logic [DATA_W-1:0] din, dout, code, d;
    logic [REG_ADDR_W-1:0] addr;
    logic [REG_DATA_W-1:0] wdata, rdata, r;
    logic [CHAN_W-1:0] ch;
    logic [CHAN_N-1:0] en;
    logic [CHAN_N/2-1:0] dp;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ahp_top ahp_top_inst (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1), .CHIP_SELECT_LOW_N_IN(csl_n),
        .CHIP_SELECT_HIGH_IN(csh), .WRITE_PIN_IN(wp), .READ_SELECT_N_IN(rdn), .DATA_IN(din), .DATA_OUT(dout),
        .DATA_OE_N_OUT(oe_n), .CONV_PIN_IN(conv), .SAMPLE_READY_FLAG_OUT(flag), .ANALOG_CODE_IN(code),
        .CHANNEL_INDEX_OUT(ch), .CHANNEL_ENABLE_OUT(en), .DIFF_PAIR_OUT(dp), .EXT_REF_SELECT_OUT(ext_ref),
        .SINGLE_MODE_OUT(single), .SAMPLE_HOLD_OUT(hold), .CONVERT_STEP_OUT(step), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq));
    ahp_host_model ahp_host_model_inst (.clk_in(clk), .dev_data_in(dout), .dev_oe_n_in(oe_n),
        .cs_low_n_out(csl_n), .cs_high_out(csh), .write_pin_out(wp), .read_n_out(rdn), .bus_out(din));
    always @(posedge clk) begin
        code <= 12'hA50 | {10'h000, ch};
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(negedge clk);
    endtask : reg_wr
    task automatic reg_rd(input logic [REG_ADDR_W-1:0] a, output logic [REG_DATA_W-1:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask : reg_rd
    task automatic conv_cyc;
        @(posedge clk);
        conv <= 1'b0;
        repeat (3) @(posedge clk);
        conv <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : conv_cyc
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        rst_b = 1'b0;
        conv = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        ahp_host_model_inst.host_read(1'b1, 1'b0, 1'b0, d, drv);
        chk(drv, 1'b0);
        ahp_host_model_inst.host_write(2'h0, 10'h085);
        @(negedge clk);
        chk({ext_ref, single, dp, en}, {1'b1, 1'b0, 2'h2, 4'h1});
        ahp_host_model_inst.host_write(2'h1, 10'h028);
        reg_wr(OFS_IRQ_MASK, 32'h0);
        for (int k = 1; k <= 9; k++) begin
            conv_cyc();
            chk(flag, k < 9);
        end
        $display("continuous latency done");
        chk(irq, 1'b0);
        reg_rd(OFS_IRQ_STATUS, r);
        chk(r[IRQ_READY], 1'b1);
        reg_wr(OFS_IRQ_MASK, 32'h1);
        chk(irq, 1'b1);
        reg_wr(OFS_IRQ_STATUS, 32'h1);
        chk(irq, 1'b0);
        reg_rd(8'h20, r);
        chk(r, 32'h0);
        ahp_host_model_inst.host_write(2'h1, 10'h022);
        chk(flag, 1'b1);
        ahp_host_model_inst.host_write(2'h1, 10'h026);
        chk(flag, 1'b0);
        ahp_host_model_inst.host_write(2'h1, 10'h021);
        ahp_host_model_inst.host_read(1'b1, 1'b0, 1'b1, d, drv);
        chk(drv, 1'b0);
        ahp_host_model_inst.host_read(1'b0, 1'b0, 1'b0, d, drv);
        chk(drv, 1'b0);
        ahp_host_model_inst.host_read(1'b1, 1'b1, 1'b0, d, drv);
        chk(drv, 1'b0);
        ahp_host_model_inst.host_read(1'b1, 1'b0, 1'b0, d, drv);
        chk({drv, d}, {1'b1, 12'hA50});
        ahp_host_model_inst.host_write(2'h1, 10'h020);
        ahp_host_model_inst.host_read(1'b1, 1'b0, 1'b1, d, drv);
        chk({drv, d}, {1'b1, 12'hA50});
        $display("host strobe schemes done");
        ahp_host_model_inst.host_write(2'h0, 10'h03E);
        ahp_host_model_inst.host_write(2'h1, 10'h048);
        chk(single, 1'b1);
        reg_wr(OFS_IRQ_STATUS, 32'hF);
        @(posedge clk);
        conv <= 1'b0;
        repeat (2) @(posedge clk);
        conv <= 1'b1;
        for (int i = 0; i < 300 && flag !== 1'b0; i++) begin
            @(negedge clk);
        end
        chk(flag, 1'b0);
        repeat (8) @(posedge clk);
        reg_rd(OFS_IRQ_STATUS, r);
        chk(r[IRQ_SINGLE_DONE], 1'b1);
        for (int c = 0; c < 4; c++) begin
            ahp_host_model_inst.host_read(1'b1, 1'b0, 1'b1, d, drv);
            chk(d, 12'hA50 | c);
        end
        $display("single conversion done");
        end_sim();
    end
endmodule : ahp_top_tb_top
`default_nettype wire
